/* verilog/dcfg_regs.sv */
/*
 * Display controller configuration bank: write lock, general
 * configuration, palette index/data, FIFO RAM test ports, fetch address.
 * Assumes an AXI4-Lite master with one read and one write outstanding,
 * and display pipeline strobes on aclk.
 */
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`include "dcfg_params.svh"

module dcfg_regs (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [15:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [15:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire dcfg_pkg::dcfg_fetch_s fetch_in,
    output dcfg_pkg::dcfg_general_s general_config,
    output logic dot_clock_en,
    output logic pixel_clock_en,
    output logic [19:0] fetch_addr
);
    import dcfg_pkg::*;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
        hit = (a[15:2] == o[15:2]);
    endfunction : hit

    function automatic dcfg_word_t merge(input dcfg_word_t old,
                                         input dcfg_word_t nw,
                                         input logic [3:0] be);
        dcfg_word_t r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        merge = r;
    endfunction : merge

    // write channel holding
    logic aw_held, w_held;
    logic [15:0] wr_addr;
    dcfg_word_t wr_data;
    logic [3:0] wr_strb;

    // register state
    logic [15:0] unlock_key;
    dcfg_word_t timing_config, output_config;
    logic [10:0] split_line_value;
    logic [7:0] palette_index;
    logic [23:0] palette [`DCFG_PAL_DEPTH];
    dcfg_word_t dfifo_ram [`DCFG_RAM_DEPTH];
    dcfg_word_t lbuf_ram [`DCFG_RAM_DEPTH];
    logic [3:0] dfifo_wp, dfifo_rp, lbuf_wp, lbuf_rp;
    logic test_mode_prev;

    wire aw_fire = awvalid && awready;
    wire w_fire = wvalid && wready;
    wire ar_fire = arvalid && arready;
    wire b_fire = bvalid && bready;
    wire r_fire = rvalid && rready;
    wire do_write = aw_held && w_held && !bvalid;
    wire next_aw_held = aw_fire || (aw_held && !do_write);
    wire next_w_held = w_fire || (w_held && !do_write);

    wire locked = (unlock_key != `DCFG_UNLOCK_CODE); // R01 R02
    dcfg_word_t wr_general, wr_unlock_w, wr_timing, wr_output;
    assign wr_general = merge(general_config, wr_data, wr_strb);
    assign wr_unlock_w = merge({16'h0000, unlock_key}, wr_data, wr_strb);
    assign wr_timing = merge(timing_config, wr_data, wr_strb);
    assign wr_output = merge(output_config, wr_data, wr_strb);

    // write decode; the four group words sit at consecutive words
    wire w_unlock = hit(wr_addr, `DCFG_OFS_UNLOCK); // R05
    wire w_general = hit(wr_addr, `DCFG_OFS_GENERAL);
    wire w_timing = hit(wr_addr, `DCFG_OFS_TIMING);
    wire w_output = hit(wr_addr, `DCFG_OFS_OUTPUT);
    wire w_split = hit(wr_addr, `DCFG_OFS_SPLIT);
    wire w_pindex = hit(wr_addr, `DCFG_OFS_PAL_INDEX);
    wire w_pdata = hit(wr_addr, `DCFG_OFS_PAL_DATA);
    wire w_dfifo = hit(wr_addr, `DCFG_OFS_DFIFO);
    wire w_lbuf = hit(wr_addr, `DCFG_OFS_LBUF);
    wire w_mapped = w_unlock || w_general || w_timing || w_output ||
                    w_split || w_pindex || w_pdata || w_dfifo || w_lbuf;
    wire w_protected = w_general || w_timing || w_output; // R03
    wire write_ok = do_write && !(w_protected && locked); // R04

    // read decode
    wire r_unlock = hit(araddr, `DCFG_OFS_UNLOCK);
    wire r_general = hit(araddr, `DCFG_OFS_GENERAL);
    wire r_timing = hit(araddr, `DCFG_OFS_TIMING);
    wire r_output = hit(araddr, `DCFG_OFS_OUTPUT);
    wire r_split = hit(araddr, `DCFG_OFS_SPLIT);
    wire r_pindex = hit(araddr, `DCFG_OFS_PAL_INDEX);
    wire r_pdata = hit(araddr, `DCFG_OFS_PAL_DATA);
    wire r_dfifo = hit(araddr, `DCFG_OFS_DFIFO);
    wire r_lbuf = hit(araddr, `DCFG_OFS_LBUF);
    wire r_mapped = r_unlock || r_general || r_timing || r_output ||
                    r_split || r_pindex || r_pdata || r_dfifo || r_lbuf;

    // test ports only reach the RAMs in test mode; otherwise inert
    wire test_on = general_config.fifo_test_mode;
    wire test_rise = test_on && !test_mode_prev;
    wire dfifo_wr = write_ok && w_dfifo && test_on; // R08
    wire lbuf_wr = write_ok && w_lbuf && test_on; // R09
    wire dfifo_rd = ar_fire && r_dfifo && test_on; // R08
    wire lbuf_rd = ar_fire && r_lbuf && test_on; // R09

    dcfg_word_t next_rdata;
    assign next_rdata =
        r_unlock ? {16'h0000, unlock_key} :
        r_general ? general_config :
        r_timing ? timing_config :
        r_output ? output_config :
        r_split ? {21'h000000, split_line_value} :
        r_pindex ? {24'h000000, palette_index} :
        r_pdata ? {8'h00, palette[palette_index]} : // R07
        dfifo_rd ? dfifo_ram[dfifo_rp] :
        lbuf_rd ? lbuf_ram[lbuf_rp] :
        32'h0000_0000;

    // bus handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `DCFG_RESP_OKAY;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            awready <= !next_aw_held;
            wready <= !next_w_held;
            if (do_write) begin
                bvalid <= 1'b1;
                bresp <= w_mapped ? `DCFG_RESP_OKAY : `DCFG_RESP_DECERR;
            end else if (b_fire) begin
                bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (aw_fire) begin
            wr_addr <= awaddr;
        end
        if (w_fire) begin
            wr_data <= wdata;
            wr_strb <= wstrb;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `DCFG_RESP_OKAY;
        end else begin
            if (ar_fire) begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rdata <= next_rdata;
                rresp <= r_mapped ? `DCFG_RESP_OKAY : `DCFG_RESP_DECERR;
            end else begin
                if (r_fire) begin
                    rvalid <= 1'b0;
                end
                if (r_fire || !rvalid) begin
                    arready <= 1'b1;
                end
            end
        end
    end

    // control registers; upper half of the unlock word is not stored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            unlock_key <= 16'h0000;
            general_config <= `DCFG_RST_WORD;
            timing_config <= `DCFG_RST_WORD;
            output_config <= `DCFG_RST_WORD;
            split_line_value <= `DCFG_RST_SPLIT;
            palette_index <= `DCFG_RST_INDEX;
            test_mode_prev <= 1'b0;
        end else begin
            test_mode_prev <= test_on;
            if (write_ok && w_unlock) begin
                unlock_key <= wr_unlock_w[15:0]; // R01 R02
            end
            if (write_ok && w_general) begin
                general_config <= wr_general; // R04 R12 R13
            end
            if (write_ok && w_timing) begin
                timing_config <= wr_timing;
            end
            if (write_ok && w_output) begin
                output_config <= wr_output;
            end
            if (write_ok && w_split) begin
                split_line_value <= wr_data[10:0];
            end
            if (write_ok && w_pindex && wr_strb[0]) begin
                palette_index <= wr_data[7:0]; // R06
            end
        end
    end

    // palette storage has no reset; software loads it
    always_ff @(posedge aclk) begin
        if (write_ok && w_pdata) begin
            palette[palette_index] <= wr_data[23:0]; // R06 R07
        end
    end

    always_ff @(posedge aclk) begin
        if (dfifo_wr) begin
            dfifo_ram[dfifo_wp] <= wr_data;
        end
        if (lbuf_wr) begin
            lbuf_ram[lbuf_wp] <= wr_data;
        end
    end

    // pointer reset on test mode rise beats a same-cycle access
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dfifo_wp <= 4'h0;
            dfifo_rp <= 4'h0;
            lbuf_wp <= 4'h0;
            lbuf_rp <= 4'h0;
        end else begin
            if (test_rise) begin
                dfifo_wp <= 4'h0; // R16
                dfifo_rp <= 4'h0; // R16
                lbuf_rp <= 4'h0; // R17
            end else begin
                if (dfifo_wr) begin
                    dfifo_wp <= dfifo_wp + 4'h1;
                end
                if (dfifo_rd) begin
                    dfifo_rp <= dfifo_rp + 4'h1;
                end
                if (lbuf_rd) begin
                    lbuf_rp <= lbuf_rp + 4'h1;
                end
            end
            if (lbuf_wr && !test_rise) begin
                lbuf_wp <= lbuf_wp + 4'h1;
            end
        end
    end

    // clock enables; protocol and video bits leave on general_config
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dot_clock_en <= 1'b1;
            pixel_clock_en <= 1'b1;
        end else begin
            dot_clock_en <= general_config.dot_clock_halve ?
                            !dot_clock_en : 1'b1; // R10
            pixel_clock_en <= general_config.pixel_clock_halve ?
                              !pixel_clock_en : 1'b1; // R11
        end
    end

    // frame buffer fetch address
    wire split_hit = general_config.split_screen_enable &&
                     fetch_in.line_strobe &&
                     (fetch_in.line_count == split_line_value); // R14
    wire [19:0] step = general_config.chain_four_skip ?
                       `DCFG_FETCH_STEP_4 : `DCFG_FETCH_STEP_1; // R15

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fetch_addr <= 20'h00000;
        end else if (fetch_in.frame_start || split_hit) begin
            fetch_addr <= 20'h00000; // R14
        end else if (fetch_in.fetch_step) begin
            fetch_addr <= fetch_addr + step; // R15
        end
    end

    property p_locked_drop;
        @(posedge aclk) disable iff (!aresetn)
        do_write && w_general && locked |=> $stable(general_config);
    endproperty
    a_locked_drop: assert property (p_locked_drop) // R04
        else $error("locked write changed general configuration");

    property p_unlock;
        @(posedge aclk) disable iff (!aresetn)
        do_write && w_unlock && (wr_strb[1:0] == 2'h3) &&
        (wr_data[15:0] == `DCFG_UNLOCK_CODE) |=> !locked;
    endproperty
    a_unlock: assert property (p_unlock) // R01
        else $error("key write did not unlock");

    property p_relock;
        @(posedge aclk) disable iff (!aresetn)
        do_write && w_unlock && (wr_strb[1:0] == 2'h3) &&
        (wr_data[15:0] != `DCFG_UNLOCK_CODE) |=> locked ##1 locked;
    endproperty
    a_relock: assert property (p_relock) // R02
        else $error("non-key write did not re-arm lock");

    property p_split;
        @(posedge aclk) disable iff (!aresetn)
        split_hit |=> (fetch_addr == 20'h00000);
    endproperty
    a_split: assert property (p_split) // R14
        else $error("split line match did not clear fetch address");

    property p_chain;
        @(posedge aclk) disable iff (!aresetn)
        fetch_in.fetch_step && !fetch_in.frame_start && !split_hit
        |=> (fetch_addr - $past(fetch_addr) ==
             ($past(general_config.chain_four_skip) ?
              `DCFG_FETCH_STEP_4 : `DCFG_FETCH_STEP_1));
    endproperty
    a_chain: assert property (p_chain) // R15
        else $error("fetch address step wrong");

    property p_dot;
        @(posedge aclk) disable iff (!aresetn)
        general_config.dot_clock_halve [*2] |->
        dot_clock_en != $past(dot_clock_en);
    endproperty
    a_dot: assert property (p_dot) // R10
        else $error("dot clock enable not halving");

    property p_pix;
        @(posedge aclk) disable iff (!aresetn)
        !general_config.pixel_clock_halve ##1 1'b1 |-> pixel_clock_en;
    endproperty
    a_pix: assert property (p_pix) // R11
        else $error("pixel clock enable gated while not halving");

    property p_dfifo_rst;
        @(posedge aclk) disable iff (!aresetn)
        $rose(general_config.fifo_test_mode) |=>
        (dfifo_wp == 4'h0) && (dfifo_rp == 4'h0);
    endproperty
    a_dfifo_rst: assert property (p_dfifo_rst) // R16
        else $error("display FIFO pointers not reset");

    property p_lbuf_rst;
        @(posedge aclk) disable iff (!aresetn)
        $rose(general_config.fifo_test_mode) |=> (lbuf_rp == 4'h0);
    endproperty
    a_lbuf_rst: assert property (p_lbuf_rst) // R17
        else $error("line buffer read pointer not reset");

endmodule : dcfg_regs

/* verilog/dcfg_params.svh */
/*
 * Offsets, field positions, reset values and sizes of the display
 * configuration, lock and palette register bank.
 * Assumes byte addresses on a 16-bit AXI4-Lite address, one word each.
 */
// Functional notes
// R01 - key 4758h in low half unlocks writes
// R02 - any other unlock value re-arms the lock
// R03 - lock guards config, timing, output registers
// R04 - locked writes dropped; reads still return values
// R05 - four 32-bit group registers from base
// R06 - palette index selects entry for data access
// R07 - palette data access hits indexed entry
// R08 - display FIFO RAM test read/write port
// R09 - line buffer RAM test read/write port
// R10 - dot clock halve runs dot at half
// R11 - pixel clock halve runs pixel at half
// R12 - protocol bit: 0 low, 1 high speed
// R13 - video enable turns motion port on
// R14 - split line match resets fetch address
// R15 - chain-four skip fetches every fourth dword
// R16 - test mode rise resets FIFO pointers
// R17 - test mode rise resets line buffer read
`ifndef DCFG_PARAMS_SVH
`define DCFG_PARAMS_SVH

`define DCFG_UNLOCK_CODE 16'h4758
`define DCFG_OFS_UNLOCK 16'h8300
`define DCFG_OFS_GENERAL 16'h8304
`define DCFG_OFS_TIMING 16'h8308
`define DCFG_OFS_OUTPUT 16'h830c
`define DCFG_OFS_SPLIT 16'h835c
`define DCFG_OFS_PAL_INDEX 16'h8370
`define DCFG_OFS_PAL_DATA 16'h8374
`define DCFG_OFS_DFIFO 16'h8378
`define DCFG_OFS_LBUF 16'h837c

`define DCFG_RST_WORD 32'h0000_0000
`define DCFG_RST_SPLIT 11'h000
`define DCFG_RST_INDEX 8'h00

`define DCFG_BIT_DOT_HALVE 31
`define DCFG_BIT_PIX_HALVE 30
`define DCFG_BIT_PROTOCOL 29
`define DCFG_BIT_VIDEO_EN 28
`define DCFG_BIT_SPLIT_EN 27
`define DCFG_BIT_CHAIN4 26
`define DCFG_BIT_TEST_MODE 25

`define DCFG_PAL_DEPTH 256
`define DCFG_PAL_WIDTH 24
`define DCFG_RAM_DEPTH 16
`define DCFG_FETCH_STEP_1 20'h00001
`define DCFG_FETCH_STEP_4 20'h00004
`define DCFG_RESP_OKAY 2'h0
`define DCFG_RESP_DECERR 2'h3

`endif

/* verilog/dcfg_pkg.sv */
/*
 * Types shared by the display configuration register bank.
 * Assumes dcfg_params.svh for the bit positions it mirrors.
 */
package dcfg_pkg;

    // field order matches the general configuration word, msb first
    typedef struct packed {
        logic dot_clock_halve;
        logic pixel_clock_halve;
        logic video_protocol_select;
        logic video_port_enable;
        logic split_screen_enable;
        logic chain_four_skip;
        logic fifo_test_mode;
        logic [24:0] other;
    } dcfg_general_s;

    // fetch side inputs from the display pipeline, same clock
    typedef struct packed {
        logic line_strobe;
        logic frame_start;
        logic fetch_step;
        logic [10:0] line_count;
    } dcfg_fetch_s;

    typedef logic [31:0] dcfg_word_t;

endpackage : dcfg_pkg

/* sim/dcfg_regs_tb.sv */
/*
 * Self-checking bench for the display configuration register bank:
 * lock, palette, test ports, clock halving, fetch address, decode errors.
 * Assumes dcfg_regs, dcfg_pkg and dcfg_params.svh; no partner model.
 */
`timescale 1ns/1ps
`include "dcfg_params.svh"

module dcfg_regs_tb;
    import dcfg_pkg::*;
    localparam logic [15:0] a_unl = `DCFG_OFS_UNLOCK;
    localparam logic [15:0] a_gen = `DCFG_OFS_GENERAL;
    localparam logic [15:0] a_tim = `DCFG_OFS_TIMING;
    localparam logic [15:0] a_pix = `DCFG_OFS_PAL_INDEX;
    localparam logic [15:0] a_pdat = `DCFG_OFS_PAL_DATA;
    localparam logic [15:0] a_df = `DCFG_OFS_DFIFO;
    localparam logic [15:0] a_lb = `DCFG_OFS_LBUF;
    localparam logic [1:0] ok = `DCFG_RESP_OKAY;
    logic aclk = 0;
    logic aresetn = 0;
    logic [15:0] awaddr = '0;
    logic [15:0] araddr = '0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    dcfg_fetch_s fetch_in = '0;
    dcfg_general_s general_config;
    logic dot_clock_en, pixel_clock_en;
    logic [19:0] fetch_addr;
    int failures = 0;
    int n_checks = 0;

    dcfg_regs dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .fetch_in,
        .general_config, .dot_clock_en, .pixel_clock_en, .fetch_addr);

    always #25 aclk = ~aclk;

    task automatic chk(input logic [31:0] got, exp, input string m);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got,
                exp);
        end
    endtask : chk

    task automatic chk_resp(input logic [1:0] got, exp, input string m);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s resp %h exp %h", $time, m, got,
                exp);
        end
    endtask : chk_resp

    // both channels offered together, each released when taken
    task automatic wr(input logic [15:0] a, input logic [31:0] d,
            input logic [1:0] er = `DCFG_RESP_OKAY);
        bit ad, dd;
        ad = 0;
        dd = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) begin
                ad = 1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready === 1'b1) begin
                dd = 1;
                wvalid <= 1'b0;
            end
        end while (!(ad && dd));
        while (bvalid !== 1'b1) @(posedge aclk);
        chk_resp(bresp, er, "write response");
        bready <= 1'b0;
    endtask : wr

    task automatic rdchk(input logic [15:0] a, input logic [31:0] exp,
            input logic [1:0] er = `DCFG_RESP_OKAY);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        chk(rdata, exp, "read data");
        chk_resp(rresp, er, "read response");
        rready <= 1'b0;
    endtask : rdchk

    // one-cycle strobe on the fetch side, then let the update land
    task automatic pulse(input logic [2:0] k, input logic [10:0] ln);
        @(posedge aclk);
        fetch_in <= {k, ln};
        @(posedge aclk);
        fetch_in <= {3'b000, ln};
        @(posedge aclk);
        #1;
    endtask : pulse

    task automatic t_reset;
        rdchk(a_unl, 32'h0000_0000);
        rdchk(a_gen, 32'h0000_0000);
        chk(general_config, 32'h0000_0000, "config port at reset");
        chk(dot_clock_en, 1'b1, "dot enable at reset");
        chk(pixel_clock_en, 1'b1, "pixel enable at reset");
    endtask : t_reset

    task automatic t_lock;
        wr(a_gen, 32'h3000_0000);
        rdchk(a_gen, 32'h0000_0000);
        wr(a_tim, 32'h0000_0055);
        rdchk(a_tim, 32'h0000_0000);
        wr(`DCFG_OFS_OUTPUT, 32'h0000_0066);
        rdchk(`DCFG_OFS_OUTPUT, 32'h0000_0000);
        wr(a_unl, 32'h0000_4758);
        rdchk(a_unl, 32'h0000_4758);
        wr(a_gen, 32'h3000_0000);
        rdchk(a_gen, 32'h3000_0000);
        chk(general_config.video_protocol_select, 1'b1, "protocol");
        chk(general_config.video_port_enable, 1'b1, "video on");
        wr(a_tim, 32'h0000_0055);
        rdchk(a_tim, 32'h0000_0055);
        wr(`DCFG_OFS_OUTPUT, 32'h0000_0066);
        rdchk(`DCFG_OFS_OUTPUT, 32'h0000_0066);
        wr(a_unl, 32'h0000_4759);
        wr(a_gen, 32'h2000_0000);
        rdchk(a_gen, 32'h3000_0000);
        wr(a_unl, 32'h0000_4758);
        wr(a_gen, 32'h2000_0000);
        chk(general_config.video_port_enable, 1'b0, "video off");
    endtask : t_lock

    task automatic t_palette;
        wr(a_pix, 32'h0000_0005);
        wr(a_pdat, 32'h0012_3456);
        wr(a_pix, 32'h0000_0006);
        wr(a_pdat, 32'hff00_0011);
        wr(a_pix, 32'h0000_0005);
        rdchk(a_pdat, 32'h0012_3456);
        rdchk(a_pix, 32'h0000_0005);
        wr(a_pix, 32'h0000_0006);
        rdchk(a_pdat, 32'h0000_0011);
    endtask : t_palette

    task automatic t_test_ports;
        rdchk(a_df, 32'h0000_0000);
        wr(a_df, 32'h0000_00a1);
        wr(a_gen, 32'h2200_0000);
        wr(a_df, 32'h0000_0011);
        wr(a_df, 32'h0000_0022);
        rdchk(a_df, 32'h0000_0011);
        rdchk(a_df, 32'h0000_0022);
        wr(a_lb, 32'h0000_0033);
        wr(a_lb, 32'h0000_0044);
        rdchk(a_lb, 32'h0000_0033);
        rdchk(a_lb, 32'h0000_0044);
        wr(a_gen, 32'h2000_0000);
        rdchk(a_lb, 32'h0000_0000);
        wr(a_gen, 32'h2200_0000);
        wr(a_df, 32'h0000_0055);
        rdchk(a_df, 32'h0000_0055);
        rdchk(a_lb, 32'h0000_0033);
        wr(a_gen, 32'h2000_0000);
    endtask : t_test_ports

    // enable must alternate every cycle while halving
    task automatic t_halve(input logic [31:0] cfg, input bit dot);
        logic p;
        wr(a_gen, cfg);
        repeat (2) @(posedge aclk);
        #1;
        p = dot ? dot_clock_en : pixel_clock_en;
        repeat (4) begin
            @(posedge aclk);
            #1;
            chk(dot ? dot_clock_en : pixel_clock_en, !p, "halved enable");
            chk(dot ? pixel_clock_en : dot_clock_en, 1'b1, "other enable");
            p = ~p;
        end
    endtask : t_halve

    task automatic t_fetch;
        pulse(3'b010, 11'd0);
        chk(fetch_addr, 20'h00000, "frame start");
        repeat (3) pulse(3'b001, 11'd0);
        chk(fetch_addr, 20'h00003, "step by one");
        wr(a_gen, 32'h2400_0000);
        pulse(3'b001, 11'd0);
        chk(fetch_addr, 20'h00007, "step by four");
        wr(`DCFG_OFS_SPLIT, 32'h0000_0009);
        wr(a_gen, 32'h2800_0000);
        pulse(3'b100, 11'd8);
        chk(fetch_addr, 20'h00007, "no split match");
        pulse(3'b100, 11'd9);
        chk(fetch_addr, 20'h00000, "split match");
        wr(a_gen, 32'h2000_0000);
        pulse(3'b001, 11'd0);
        pulse(3'b100, 11'd9);
        chk(fetch_addr, 20'h00001, "split disabled");
        pulse(3'b010, 11'd0);
        chk(fetch_addr, 20'h00000, "frame start clears");
    endtask : t_fetch

    task automatic conclude;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_lock();
        t_palette();
        t_test_ports();
        t_halve(32'ha000_0000, 1'b1);
        t_halve(32'h6000_0000, 1'b0);
        t_fetch();
        wr(16'h8360, 32'h0000_0001, `DCFG_RESP_DECERR);
        rdchk(16'h8360, 32'h0000_0000, `DCFG_RESP_DECERR);
        conclude();
    end

    // whole sequence needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        conclude();
    end
endmodule : dcfg_regs_tb
